// File: logic/dsp_pkg.sv
// Constants shared by the serial host port of the output converter.
`default_nettype none
package dsp_pkg;
  // Frame lengths in falling serial clock edges.
  localparam logic [5:0] FRAME_BITS = 6'h18;
  localparam logic [5:0] FRAME_BITS_CRC = 6'h20;
  localparam logic [5:0] EDGE_MAX = 6'h3f;
  // Field positions inside the 24-bit word.
  localparam int ADDR_MSB = 23;
  localparam int ADDR_LSB = 16;
  localparam int DATA_MSB = 15;
  // Command addresses.
  localparam logic [7:0] ADDR_PENDING = 8'h01;
  localparam logic [7:0] ADDR_CONFIG = 8'h02;
  localparam logic [7:0] ADDR_READSEL = 8'h03;
  localparam logic [7:0] ADDR_OUTPUT = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h05;
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h0e;
  localparam logic [15:0] SOFT_RESET_KEY = 16'h1234;
  // Fields of general_config_one.
  localparam int CFG_CLK_EN = 0;
  localparam int CFG_DIV_LSB = 1;
  localparam int CFG_DIV_MSB = 3;
  localparam int CFG_MODEM = 4;
  localparam int CFG_CRC_EN = 5;
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam logic [15:0] CODE_RESET = 16'h0000;
  localparam logic [7:0] CRC_POLY = 8'h07;
  // Timing.
  localparam int CLK_KHZ = 25000;
  localparam int LOCKOUT_US = 100;
  localparam logic [11:0] LOCKOUT_CYCLES =
    12'((LOCKOUT_US * CLK_KHZ + 999) / 1000);
  // The 10 MHz oscillator is made from the 25 MHz clock as 2 ticks per 5.
  localparam logic [2:0] OSC_STEP = 3'h2;
  localparam logic [2:0] OSC_MOD = 3'h5;
  // Synchroniser input order and idle levels.
  localparam int SYNC_W = 6;
  localparam logic [5:0] SYNC_IDLE = 6'h1e;
endpackage : dsp_pkg
`default_nettype wire

// File: logic/dsp_sync.sv
// Two flip-flop synchroniser for a group of independent pin levels.
`default_nettype none
module dsp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] IDLE = '0
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);
  logic [WIDTH-1:0] first;
  // The first stage is read only by the second stage.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      first <= IDLE;
      level_o <= IDLE;
    end else begin
      first <= pin_i;
      level_o <= first;
    end
  end
endmodule : dsp_sync
`default_nettype wire

// File: logic/dsp_host_port.sv
// Serial host port: frame receiver, readback, load strobe, clock output.
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// Contract
// - Each serial bit is shifted in on a falling serial clock edge.
// - In readback the serial register shifts out on the data output.
// - Low reset input returns the logic to its power-on state.
// - Low load strobe copies the pending code into the output code.
// - Clock output divides the 10 MHz oscillator per general_config_one.
// - Clock output is off after reset until software enables it.
// - Modem input couples to the loop only while its enable bit is set.
// - Frame select is active low; data moves in while it is low.
// - Fault pin is open drain, pulled low on checksum error or overtemp.
// - Edges past the 24th, or 32nd with checksum, shift out zeros.
module dsp_host_port (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic sdi_i,
  input wire logic frame_n_i,
  input wire logic reset_n_i,
  input wire logic load_output_n_i,
  input wire logic overtemp_i,
  output logic sdo_o,
  output logic fault_n_o,
  output logic fault_n_oe_o,
  output logic divided_clock_out_o,
  output logic loop_modem_couple_en_o,
  output logic [15:0] output_code_o
);
  ////////////////////////////////////////////////////////////////////////
  logic [dsp_pkg::SYNC_W-1:0] level;
  logic s_sclk, s_sdi, s_frame_n, s_reset_n, s_load_n, s_overtemp;

  dsp_sync #(
    .WIDTH(dsp_pkg::SYNC_W),
    .IDLE(dsp_pkg::SYNC_IDLE)
  ) u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .pin_i({overtemp_i, load_output_n_i, reset_n_i, frame_n_i, sdi_i,
      sclk_i}),
    .level_o(level)
  );
  assign {s_overtemp, s_load_n, s_reset_n, s_frame_n, s_sdi, s_sclk} = level;

  // A synchronised serial clock limits this port to well under the
  // system clock; faster host clocks need a dedicated link clock domain.
  ////////////////////////////////////////////////////////////////////////
  logic sclk_q, frame_q, rb_armed, crc_fault, fault_oe, sdo;
  logic [5:0] edge_cnt;
  logic [31:0] shift_in, shift_out;
  logic [7:0] rb_addr;
  logic [15:0] pending_code, output_code, config_reg;
  logic [11:0] lock_cnt;
  logic next_sclk_q, next_frame_q, next_rb_armed, next_crc_fault;
  logic next_fault_oe, next_sdo;
  logic [5:0] next_edge_cnt;
  logic [31:0] next_shift_in, next_shift_out;
  logic [7:0] next_rb_addr;
  logic [15:0] next_pending_code, next_output_code, next_config;
  logic [11:0] next_lock_cnt;

  function automatic logic [7:0] crc8(input logic [23:0] word);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ word[i]) ? dsp_pkg::CRC_POLY : 8'h00);
    end
    return c;
  endfunction : crc8

  function automatic logic [15:0] read_value(input logic [7:0] addr,
      input logic [15:0] pend, input logic [15:0] cfg,
      input logic [15:0] outc, input logic [1:0] stat);
    logic [15:0] v;
    v = 16'h0000;
    unique case (addr)
      dsp_pkg::ADDR_PENDING: v = pend;
      dsp_pkg::ADDR_CONFIG: v = cfg;
      dsp_pkg::ADDR_OUTPUT: v = outc;
      dsp_pkg::ADDR_STATUS: v = {14'h0000, stat};
      default: v = 16'h0000;
    endcase
    return v;
  endfunction : read_value

  logic fall, frame_start, frame_end, crc_on, len_ok;
  logic [23:0] word, rb_word;
  logic [7:0] rx_crc;
  logic [5:0] frame_len;

  always_comb begin
    fall = sclk_q & ~s_sclk;
    frame_start = frame_q & ~s_frame_n;
    frame_end = ~frame_q & s_frame_n;
    crc_on = config_reg[dsp_pkg::CFG_CRC_EN];
    frame_len = crc_on ? dsp_pkg::FRAME_BITS_CRC : dsp_pkg::FRAME_BITS;
    len_ok = (edge_cnt == frame_len);
    word = crc_on ? shift_in[31:8] : shift_in[23:0];
    rx_crc = shift_in[7:0];
    rb_word = {rb_addr, read_value(rb_addr, pending_code, config_reg,
      output_code, {s_overtemp, crc_fault})};

    next_sclk_q = s_sclk;
    next_frame_q = s_frame_n;
    next_edge_cnt = edge_cnt;
    next_shift_in = shift_in;
    next_shift_out = shift_out;
    next_rb_addr = rb_addr;
    next_rb_armed = rb_armed;
    next_pending_code = pending_code;
    next_output_code = output_code;
    next_config = config_reg;
    next_crc_fault = crc_fault;
    next_lock_cnt = (lock_cnt != 12'h000) ? lock_cnt - 12'h001 : lock_cnt;

    if (frame_start) begin
      next_edge_cnt = 6'h00;
      // Readback data only leaves in the frame after a select command.
      next_shift_out = rb_armed ? {rb_word, crc_on ? crc8(rb_word) : 8'h00}
        : 32'h0000_0000;
    end else if (~s_frame_n && fall) begin
      next_shift_in = {shift_in[30:0], s_sdi};
      // Zero fill means edges past the frame length shift out zeros.
      next_shift_out = {shift_out[30:0], 1'b0};
      if (edge_cnt != dsp_pkg::EDGE_MAX) begin
        next_edge_cnt = edge_cnt + 6'h01;
      end
    end

    if (frame_end) begin
      next_rb_armed = 1'b0;
      // Frames during the reset lockout and short or long frames are lost.
      if (len_ok && lock_cnt == 12'h000) begin
        if (crc_on && crc8(word) != rx_crc) begin
          next_crc_fault = 1'b1;
        end else begin
          unique case (word[dsp_pkg::ADDR_MSB:dsp_pkg::ADDR_LSB])
            dsp_pkg::ADDR_PENDING: next_pending_code = word[15:0];
            dsp_pkg::ADDR_CONFIG: next_config = word[15:0];
            dsp_pkg::ADDR_READSEL: begin
              next_rb_addr = word[7:0];
              next_rb_armed = 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
    end

    if (~s_load_n) begin
      next_output_code = pending_code;
    end

    // Pin or soft reset restores power-on values and starts the lockout.
    if (~s_reset_n || (frame_end && len_ok && lock_cnt == 12'h000 &&
        !(crc_on && crc8(word) != rx_crc) &&
        word[23:16] == dsp_pkg::ADDR_SOFT_RESET &&
        word[15:0] == dsp_pkg::SOFT_RESET_KEY)) begin
      next_edge_cnt = 6'h00;
      next_shift_out = 32'h0000_0000;
      next_rb_addr = 8'h00;
      next_rb_armed = 1'b0;
      next_pending_code = dsp_pkg::CODE_RESET;
      next_output_code = dsp_pkg::CODE_RESET;
      next_config = dsp_pkg::CONFIG_RESET;
      next_crc_fault = 1'b0;
      next_lock_cnt = dsp_pkg::LOCKOUT_CYCLES;
    end

    next_fault_oe = next_crc_fault | s_overtemp;
    next_sdo = ~s_frame_n & next_shift_out[31];
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_q <= 1'b0;
      frame_q <= 1'b1;
      edge_cnt <= 6'h00;
      shift_in <= 32'h0000_0000;
      shift_out <= 32'h0000_0000;
      rb_addr <= 8'h00;
      rb_armed <= 1'b0;
      pending_code <= dsp_pkg::CODE_RESET;
      output_code <= dsp_pkg::CODE_RESET;
      config_reg <= dsp_pkg::CONFIG_RESET;
      crc_fault <= 1'b0;
      lock_cnt <= dsp_pkg::LOCKOUT_CYCLES;
      fault_oe <= 1'b0;
      sdo <= 1'b0;
    end else begin
      sclk_q <= next_sclk_q;
      frame_q <= next_frame_q;
      edge_cnt <= next_edge_cnt;
      shift_in <= next_shift_in;
      shift_out <= next_shift_out;
      rb_addr <= next_rb_addr;
      rb_armed <= next_rb_armed;
      pending_code <= next_pending_code;
      output_code <= next_output_code;
      config_reg <= next_config;
      crc_fault <= next_crc_fault;
      lock_cnt <= next_lock_cnt;
      fault_oe <= next_fault_oe;
      sdo <= next_sdo;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  logic [2:0] osc_acc, next_osc_acc;
  logic [7:0] div_cnt, next_div_cnt;
  logic clk_out, next_clk_out, modem_en, next_modem_en;
  logic [3:0] osc_sum;

  always_comb begin
    osc_sum = {1'b0, osc_acc} + {1'b0, dsp_pkg::OSC_STEP};
    next_osc_acc = osc_acc;
    next_div_cnt = div_cnt;
    // The oscillator tick has some jitter against the 25 MHz clock.
    if (osc_sum >= {1'b0, dsp_pkg::OSC_MOD}) begin
      next_osc_acc = 3'(osc_sum - {1'b0, dsp_pkg::OSC_MOD});
      next_div_cnt = div_cnt + 8'h01;
    end else begin
      next_osc_acc = osc_sum[2:0];
    end
    next_clk_out = config_reg[dsp_pkg::CFG_CLK_EN] &
      div_cnt[config_reg[dsp_pkg::CFG_DIV_MSB:dsp_pkg::CFG_DIV_LSB]];
    next_modem_en = config_reg[dsp_pkg::CFG_MODEM];
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      osc_acc <= 3'h0;
      div_cnt <= 8'h00;
      clk_out <= 1'b0;
      modem_en <= 1'b0;
      fault_n_o <= 1'b0;
    end else begin
      osc_acc <= next_osc_acc;
      div_cnt <= next_div_cnt;
      clk_out <= next_clk_out;
      modem_en <= next_modem_en;
      fault_n_o <= 1'b0;
    end
  end

  assign sdo_o = sdo;
  assign fault_n_oe_o = fault_oe;
  assign divided_clock_out_o = clk_out;
  assign loop_modem_couple_en_o = modem_en;
  assign output_code_o = output_code;
endmodule : dsp_host_port
`default_nettype wire

// File: test/dsp_host_port_properties.sv
// Port checker for the serial host port.
`default_nettype none
module dsp_host_port_props (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic frame_n_i,
  input wire logic reset_n_i,
  input wire logic load_output_n_i,
  input wire logic overtemp_i,
  input wire logic sdo_o,
  input wire logic fault_n_o,
  input wire logic fault_n_oe_o,
  input wire logic divided_clock_out_o,
  input wire logic loop_modem_couple_en_o,
  input wire logic [15:0] output_code_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] hi_cnt, next_hi_cnt, ev_cnt, next_ev_cnt;
  logic sclk_q, frame_q;
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  // Counters saturate so that long idle spells never wrap into a false age.
  always_comb begin
    next_hi_cnt = frame_n_i ? hi_cnt + {3'h0, hi_cnt != 4'hf} : 4'h0;
    next_ev_cnt = (sclk_i != sclk_q || frame_n_i != frame_q) ? 4'h0 :
      ev_cnt + {3'h0, ev_cnt != 4'hf};
  end
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      hi_cnt <= 4'hf;
      ev_cnt <= 4'hf;
      sclk_q <= 1'b0;
      frame_q <= 1'b1;
    end else begin
      hi_cnt <= next_hi_cnt;
      ev_cnt <= next_ev_cnt;
      sclk_q <= sclk_i;
      frame_q <= frame_n_i;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_fault_drive: assert property (fault_n_oe_o |-> !fault_n_o)
    else $error("fault pin driven high");
  a_overtemp_fault: assert property (
    $rose(overtemp_i) && reset_n_i |-> ##[1:5] fault_n_oe_o)
    else $error("overtemperature not flagged");
  a_load_copy: assert property (
    $changed(output_code_o) && output_code_o != 16'h0 |->
      !$past(load_output_n_i, 2) || !$past(load_output_n_i, 3) ||
      !$past(load_output_n_i, 4) || !$past(load_output_n_i, 5))
    else $error("output code moved without load strobe");
  a_hw_reset_state: assert property (
    !reset_n_i [*6] |-> output_code_o == 16'h0 && !loop_modem_couple_en_o)
    else $error("reset pin did not clear state");
  a_clk_off_reset: assert property (
    !reset_n_i [*6] |-> !divided_clock_out_o)
    else $error("clock output running in reset");
  a_couple_frame: assert property (
    $rose(loop_modem_couple_en_o) |-> hi_cnt >= 4'h2 && hi_cnt <= 4'h8)
    else $error("coupling changed away from frame end");
  a_sdo_idle: assert property (frame_n_i [*6] |-> !sdo_o)
    else $error("data output active outside frame");
  a_sdo_shift: assert property (
    $changed(sdo_o) |-> ev_cnt <= 4'h8)
    else $error("data output moved without serial clock");
endmodule : dsp_host_port_props
`default_nettype wire

// File: test/dsp_host_model.sv
// Serial master model that frames words and gathers readback bits.
`default_nettype none
module dsp_host_model (
  input wire logic clock_i,
  input wire logic sdo_i,
  output logic sclk_o,
  output logic sdi_o,
  output logic frame_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk_o = 1'b0;
    sdi_o = 1'b1;
    frame_n_o = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Each serial half period is 4 system clocks: the port oversamples, so this
  // stays far below the top serial rates.
  task automatic xfer(input logic [31:0] w, input int n,
                      output logic [31:0] rd);
    rd = '0;
    @(posedge clock_i);
    frame_n_o <= 1'b0;
    repeat (4) @(posedge clock_i);
    for (int i = 0; i < n; i++) begin
      sclk_o <= 1'b1;
      sdi_o <= w[31 - i];
      repeat (3) @(posedge clock_i);
      @(negedge clock_i);
      rd = {rd[30:0], sdo_i};
      @(posedge clock_i);
      sclk_o <= 1'b0;
      repeat (4) @(posedge clock_i);
    end
    frame_n_o <= 1'b1;
    sdi_o <= ~sdi_o;
    repeat (8) @(posedge clock_i);
  endtask : xfer
endmodule : dsp_host_model
`default_nettype wire

// File: test/dsp_host_port_tb.sv
// Self-checking bench for the serial host port.
`default_nettype none
module dsp_host_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic reset_n_i = 1'b1;
  logic load_output_n_i = 1'b1;
  logic overtemp_i = 1'b0;
  wire sclk, sdi, frame_n;
  logic sdo_o, fault_n_o, fault_n_oe_o, divided_clock_out_o;
  logic loop_modem_couple_en_o;
  logic [15:0] output_code_o, pend = 16'h0, outc = 16'h0, dat;
  logic [31:0] rd;
  int num_errors = 0;
  int checked = 0;
  int edges, n;
  integer seed = 32'h0ec0f68a;
  always #20 clock_i = ~clock_i;
  dsp_host_port dut (.clock_i, .rst_i, .sclk_i(sclk), .sdi_i(sdi),
    .frame_n_i(frame_n), .reset_n_i, .load_output_n_i, .overtemp_i, .sdo_o,
    .fault_n_o, .fault_n_oe_o, .divided_clock_out_o, .loop_modem_couple_en_o,
    .output_code_o);
  dsp_host_model host (.clock_i, .sdo_i(sdo_o), .sclk_o(sclk), .sdi_o(sdi),
    .frame_n_o(frame_n));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic count_rise(input int cyc, output int e);
    logic p;
    e = 0;
    p = divided_clock_out_o;
    repeat (cyc) begin
      @(negedge clock_i);
      if (divided_clock_out_o && !p) e++;
      p = divided_clock_out_o;
    end
  endtask : count_rise
  // Checksum over the 24-bit word, first bit first, register cleared.
  function automatic logic [7:0] crc_of(input logic [23:0] w);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? dsp_pkg::CRC_POLY : 8'h00);
    end
    return c;
  endfunction : crc_of
  task automatic crc_xfer(input logic [23:0] w, input logic [7:0] flip);
    host.xfer({w, crc_of(w) ^ flip}, 32, rd);
  endtask : crc_xfer
  // The strobe waits out the quiet time after frame end, then stays low.
  task automatic load_pulse;
    repeat (32) @(posedge clock_i);
    load_output_n_i <= 1'b0;
    repeat (6) @(posedge clock_i);
  endtask : load_pulse
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clock_i);
    num_errors++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    count_rise(60, edges);
    check("divided_clock_out_off", edges, 0);
    check("couple_rst", loop_modem_couple_en_o, 0);
    check("code_rst", output_code_o, 0);
    // Lockout after reset must pass before the first frame.
    repeat (2600) @(posedge clock_i);
    for (int k = 0; k < 4; k++) begin
      dat = 16'($random(seed));
      n = 23 + (k % 3);
      host.xfer({dsp_pkg::ADDR_PENDING, dat, 8'h00}, n, rd);
      if (n == 24) pend = dat;
      check("code_held", output_code_o, outc);
      load_pulse();
      check("code_load", output_code_o, pend);
      outc = pend;
      load_output_n_i <= 1'b1;
    end
    host.xfer({dsp_pkg::ADDR_READSEL, 16'h0001, 8'h00}, 24, rd);
    host.xfer(32'h0, 28, rd);
    check("readback", rd[27:0], {8'h01, pend, 4'h0});
    for (int s = 0; s < 3; s++) begin
      host.xfer({dsp_pkg::ADDR_CONFIG, 16'h0011 | 16'(s << 1), 8'h00}, 24, rd);
      check("couple_on", loop_modem_couple_en_o, 1);
      count_rise(200 << s, edges);
      check("divided_clock_out_rate", edges >= 39 && edges <= 41, 1);
    end
    host.xfer({dsp_pkg::ADDR_CONFIG, 16'h0010, 8'h00}, 24, rd);
    count_rise(100, edges);
    check("divided_clock_out_dis", edges, 0);
    reset_n_i <= 1'b0;
    repeat (10) @(posedge clock_i);
    check("code_hw", output_code_o, 0);
    check("couple_hw", loop_modem_couple_en_o, 0);
    reset_n_i <= 1'b1;
    // A frame inside the lockout is refused, so loading still gives zero.
    host.xfer({dsp_pkg::ADDR_PENDING, 16'h5a5a, 8'h00}, 24, rd);
    load_pulse();
    check("code_lock", output_code_o, 0);
    load_output_n_i <= 1'b1;
    overtemp_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    check("fault_oe", fault_n_oe_o, 1);
    check("fault_low", fault_n_o, 0);
    overtemp_i <= 1'b0;
    repeat (6) @(posedge clock_i);
    check("fault_clr", fault_n_oe_o, 0);
    // Checksum mode: a good frame lands, a bad one is dropped and flagged.
    repeat (2500) @(posedge clock_i);
    host.xfer({dsp_pkg::ADDR_CONFIG, 16'h0020, 8'h00}, 24, rd);
    dat = 16'($random(seed));
    crc_xfer({dsp_pkg::ADDR_PENDING, dat}, 8'h00);
    load_pulse();
    check("crc_good", output_code_o, dat);
    load_output_n_i <= 1'b1;
    check("crc_ok", fault_n_oe_o, 0);
    crc_xfer({dsp_pkg::ADDR_PENDING, ~dat}, 8'h01);
    check("crc_flag", fault_n_oe_o, 1);
    load_pulse();
    check("crc_drop", output_code_o, dat);
    load_output_n_i <= 1'b1;
    crc_xfer({dsp_pkg::ADDR_READSEL, 16'h0005}, 8'h00);
    crc_xfer(24'h000000, 8'h00);
    check("status", rd, {8'h05, 16'h0001, crc_of(24'h050001)});
    crc_xfer({dsp_pkg::ADDR_SOFT_RESET, dsp_pkg::SOFT_RESET_KEY}, 8'h00);
    check("soft_rst", fault_n_oe_o, 0);
    wrap_up();
  end
endmodule : dsp_host_port_tb
bind dsp_host_port dsp_host_port_props u_props (.clock_i, .rst_i, .sclk_i,
  .frame_n_i, .reset_n_i, .load_output_n_i, .overtemp_i, .sdo_o, .fault_n_o,
  .fault_n_oe_o, .divided_clock_out_o, .loop_modem_couple_en_o,
  .output_code_o);
`default_nettype wire
